// [logic/fdc_read_engine.sv]
// floppy read-data command engine with AXI4-Lite register access and ISA-style DMA
//
// Operation
// - fixed precompensation shifts 125 ns at 250/300/500 kb/s, 83 ns at 1 Mb/s.
// - scaled precompensation shifts 250/208/125/83 ns for 250/300/500 kb/s and 1 Mb/s.
// - rate register picks data rate and a 4, 4.8 or 8 MHz core clock.
// - command, result and non-DMA data bytes pass through data register, paced by main status.
// - DMA enable clear floats interrupt and DMA request and ignores acknowledge.
// - read-data is opcode plus eight parameters; search starts after the last.
// - a clean sector bumps the sector number and the next one is searched.
// - multi-track reads side zero to end sector, then side one from sector one.
// - in DMA mode reading continues until terminal count; host raises it.
// - running past the end-of-track sector stops with an end-of-track error.
// - size code 0..6 gives data field of 128 shifted left by the code.
// - size code zero: data length bytes go to host, full 128 still read.
// - implied seek in mode and command: seek, settle, then search.
// - search compares track, head, sector and size with each address field.
// - address field CRC error on the match sets status one bit 5, abnormal end.
// - sector not found sets status one bit 2, abnormal end.
// - track FF sets status two bit 1; other wrong track sets status two bit 4.
// - deleted mark sets status two bit 6; skip flag skips, else read then end.
// - data CRC error sets bit 5 in status one and two, abnormal end.
// - a host write to the data register aborts a hung command.
// - interrupt at end of execution; results name the next sector after a terminal-count or deleted-mark end, else the sector being read.
// - no-DMA flag set interrupts per byte; clear uses DMA request/acknowledge.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "fdc_read_map.svh"

module fdc_read_engine (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// register bus
	input  wire fdc_read_pkg::axiReq_s axiIn,
	output      fdc_read_pkg::axiRsp_s axiOut,
	// data separator and drive
	input  wire fdc_read_pkg::diskIn_s disk,
	output      logic                  seekReq,
	output      logic [7:0]            seekTrack,
	output      logic                  headSel,
	output      logic [7:0]            precompNs,
	output      logic [1:0]            coreClkSel,
	output      logic [1:0]            rateSel,
	// system DMA and interrupt
	input  wire logic                  terminalCount,
	input  wire logic                  dmaAckN,
	output      logic                  irq,
	output      logic                  irqOe,
	output      logic                  dmaReq,
	output      logic                  dmaReqOe,
	output      logic [7:0]            dmaData
);
	import fdc_read_pkg::*;

	core_s s;
	core_s next_s;

	function automatic logic [13:0] sectorLen(input logic [7:0] code);
		sectorLen = `MIN_SECTOR << code[2:0];
	endfunction : sectorLen

	function automatic logic [13:0] xferLen(input logic [7:0] code, input logic [7:0] dtl);
		if (code == 8'h00 && {6'h00, dtl} < `MIN_SECTOR)
			xferLen = {6'h00, dtl};
		else
			xferLen = sectorLen(code);
	endfunction : xferLen

	function automatic logic [7:0] precompFor(input logic [1:0] rate, input logic scaled);
		if (!scaled)
			precompFor = (rate == `RATE_1M) ? `PRE_1M_NS : `PRE_FIXED_NS;
		else
			unique case (rate)
				`RATE_250K: precompFor = `PRE_250K_NS;
				`RATE_300K: precompFor = `PRE_300K_NS;
				`RATE_500K: precompFor = `PRE_500K_NS;
				`RATE_1M:   precompFor = `PRE_1M_NS;
			endcase
	endfunction : precompFor

	function automatic logic [1:0] coreFor(input logic [1:0] rate);
		unique case (rate)
			`RATE_250K: coreFor = `CORE_4M;
			`RATE_300K: coreFor = `CORE_4M8;
			`RATE_500K: coreFor = `CORE_8M;
			`RATE_1M:   coreFor = `CORE_8M;
		endcase
	endfunction : coreFor

	function automatic logic [7:0] mainStatus(input core_s q);
		logic exec;
		logic ready;
		exec  = q.phase inside {PH_SEEK, PH_SETTLE, PH_SEARCH, PH_MARK, PH_DATA};
		ready = (q.phase inside {PH_IDLE, PH_PARAM, PH_RESULT}) || (exec && q.noDma && q.byteFull);
		mainStatus = 8'h00;
		mainStatus[`MSR_REQUEST]    = ready;
		mainStatus[`MSR_TO_HOST]    = (q.phase == PH_RESULT) || (exec && q.byteFull);
		mainStatus[`MSR_EXEC_NODMA] = exec && q.noDma;
		mainStatus[`MSR_BUSY]       = q.phase != PH_IDLE;
	endfunction : mainStatus

	function automatic logic [7:0] resultByte(input core_s q);
		unique case (q.idx)
			4'h0:    resultByte = q.st0;
			4'h1:    resultByte = q.sb1;
			4'h2:    resultByte = q.sb2;
			4'h3:    resultByte = q.c;
			4'h4:    resultByte = q.h;
			4'h5:    resultByte = q.r;
			default: resultByte = q.n;
		endcase
	endfunction : resultByte

	function automatic logic mapped(input logic [7:0] a);
		mapped = a inside {`OFS_MAIN_STATUS, `OFS_DATA, `OFS_DRIVE_CTL, `OFS_RATE_SELECT, `OFS_MODE};
	endfunction : mapped

	// end of execution: load status zero, enter result phase, raise interrupt
	function automatic core_s finish(input core_s q, input logic abnormal);
		finish          = q;
		finish.st0      = {abnormal ? `ST0_ABNORMAL : 2'h0, 3'h0, q.hd, 2'h0};
		finish.phase    = PH_RESULT;
		finish.idx      = 4'h0;
		finish.irq      = 1'b1;
		finish.byteFull = 1'b0;
		finish.dmaReq   = 1'b0;
	endfunction : finish

	always_comb
	begin
		logic       dackEdge;
		logic       termEdge;
		logic       newByte;
		logic       exec;
		logic [7:0] rdVal;
		next_s   = s;
		dackEdge = 1'b0;
		termEdge = 1'b0;
		newByte  = 1'b0;
		rdVal    = 8'h00;
		exec     = s.phase inside {PH_SEEK, PH_SETTLE, PH_SEARCH, PH_MARK, PH_DATA};

		// pins from the DMA controller: accept a change once stages two and three agree
		next_s.termSync = {s.termSync[1:0], terminalCount};
		next_s.dackSync = {s.dackSync[1:0], ~dmaAckN};
		if (s.termSync[1] == s.termSync[2])
			next_s.termLvl = s.termSync[2];
		if (s.dackSync[1] == s.dackSync[2])
			next_s.dackLvl = s.dackSync[2];
		termEdge = next_s.termLvl && !s.termLvl;
		dackEdge = next_s.dackLvl && !s.dackLvl && s.dmaEn;

		// acknowledge takes the pending byte off the DMA request
		if (dackEdge && s.byteFull && !s.noDma)
		begin
			next_s.byteFull = 1'b0;
			next_s.dmaReq   = 1'b0;
		end
		if (termEdge && s.dmaEn && exec && !s.noDma)
			next_s.termSeen = 1'b1;

		unique case (s.phase)
			PH_IDLE, PH_PARAM, PH_RESULT: ;
			PH_SEEK:
				if (disk.seekDone)
				begin
					next_s.seekReq = 1'b0;
					next_s.settle  = 12'(`SETTLE_CYC);
					next_s.phase   = PH_SETTLE;
				end
			PH_SETTLE:
				if (s.settle <= 12'h001)
					next_s.phase = PH_SEARCH;
				else
					next_s.settle = s.settle - 12'h001;
			PH_SEARCH:
			begin
				if (disk.idValid)
				begin
					if (disk.idTrack == `BAD_TRACK_ID)
						next_s.sb2[`SB2_BAD_TRACK] = 1'b1;
					else if (disk.idTrack != s.c)
						next_s.sb2[`SB2_WRONG_TRACK] = 1'b1;
					if (disk.idTrack == s.c && disk.idHead == s.h && disk.idSector == s.r
						&& disk.idSize == s.n)
					begin
						if (disk.idCrcErr)
						begin
							next_s = finish(next_s, 1'b1);
							next_s.sb1[`SB1_CRC] = 1'b1;
						end
						else
						begin
							next_s.phase = PH_MARK;
							next_s.revs  = 2'h0;
						end
					end
				end
				else if (disk.indexPulse)
				begin
					// two passes of the index without a match means the sector is absent
					if (s.revs == 2'h1)
					begin
						next_s = finish(next_s, 1'b1);
						next_s.sb1[`SB1_NO_DATA] = 1'b1;
					end
					else
						next_s.revs = s.revs + 2'h1;
				end
			end
			PH_MARK:
				if (disk.markValid)
				begin
					next_s.byteCnt = 14'h0000;
					next_s.deleted = disk.markDeleted;
					if (disk.markDeleted)
						next_s.sb2[`SB2_CONTROL_MARK] = 1'b1;
					if (disk.markDeleted && s.opc[5])
					begin
						next_s.r     = s.r + 8'h01;
						next_s.phase = PH_SEARCH;
					end
					else
						next_s.phase = PH_DATA;
				end
			PH_DATA:
			begin
				if (disk.byteValid)
				begin
					next_s.byteCnt = s.byteCnt + 14'h0001;
					// bytes past the transfer length are read for the CRC only
					if (s.byteCnt < xferLen(s.n, s.dtl) && !s.termSeen)
					begin
						if (next_s.byteFull)
							next_s.sb1[`SB1_OVERRUN] = 1'b1;
						next_s.dataByte = disk.byteData;
						next_s.byteFull = 1'b1;
						newByte         = 1'b1;
						if (s.noDma)
							next_s.irq = 1'b1;
						else
							next_s.dmaReq = 1'b1;
					end
				end
				if (disk.fieldEnd)
				begin
					if (disk.fieldCrcErr)
					begin
						next_s = finish(next_s, 1'b1);
						next_s.sb1[`SB1_CRC]      = 1'b1;
						next_s.sb2[`SB2_DATA_CRC] = 1'b1;
					end
					else if (s.deleted || next_s.termSeen)
					begin
						next_s   = finish(next_s, 1'b0);
						next_s.r = s.r + 8'h01;
					end
					else if (s.r == s.endSec && s.opc[7] && !s.hd)
					begin
						next_s.hd    = 1'b1;
						next_s.h     = 8'h01;
						next_s.r     = 8'h01;
						next_s.phase = PH_SEARCH;
					end
					else if (s.r == s.endSec)
					begin
						next_s = finish(next_s, 1'b1);
						next_s.sb1[`SB1_END_TRACK] = 1'b1;
					end
					else
					begin
						next_s.r     = s.r + 8'h01;
						next_s.phase = PH_SEARCH;
					end
				end
			end
		endcase

		// write channel: address and data taken in either order, answered together
		if (axiIn.awvalid && s.rsp.awready)
		begin
			next_s.awHave = 1'b1;
			next_s.awAddr = axiIn.awaddr;
		end
		if (axiIn.wvalid && s.rsp.wready)
		begin
			next_s.wHave  = 1'b1;
			next_s.wData  = axiIn.wdata[7:0];
			next_s.wLane0 = axiIn.wstrb[0];
		end
		if (s.rsp.bvalid && axiIn.bready)
			next_s.rsp.bvalid = 1'b0;
		if (s.awHave && s.wHave && !s.rsp.bvalid)
		begin
			next_s.awHave     = 1'b0;
			next_s.wHave      = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp  = mapped(s.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (s.wLane0)
				unique case (s.awAddr)
					`OFS_DRIVE_CTL: next_s.dmaEn = s.wData[`BIT_DMA_ENABLE];
					`OFS_RATE_SELECT:
					begin
						next_s.rate   = s.wData[1:0];
						next_s.scaled = s.wData[`BIT_SCALED_PRE];
					end
					`OFS_MODE:
					begin
						next_s.seekEn = s.wData[`BIT_SEEK_ENABLE];
						next_s.noDma  = s.wData[`BIT_NO_DMA];
					end
					`OFS_DATA:
						if (exec)
						begin
							next_s         = finish(next_s, 1'b1);
							next_s.seekReq = 1'b0;
						end
						else if (s.phase == PH_IDLE)
						begin
							next_s.opc = s.wData;
							if (s.wData[4:0] == `OPC_READ_DATA)
							begin
								next_s.phase  = PH_PARAM;
								next_s.idx    = 4'h1;
								next_s.sb1      = 8'h00;
								next_s.sb2      = 8'h00;
								next_s.termSeen = 1'b0;
								next_s.revs   = 2'h0;
							end
							else
							begin
								// other commands load the invalid status but answer with a single byte, the size code n
								next_s.st0   = `ST0_INVALID;
								next_s.phase = PH_RESULT;
								next_s.idx   = `RESULT_LAST;
							end
						end
						else if (s.phase == PH_PARAM)
						begin
							unique case (s.idx)
								4'h1:
								begin
									next_s.seekBit = s.wData[7];
									next_s.hd  = s.wData[2];
								end
								4'h2:    next_s.c   = s.wData;
								4'h3:    next_s.h   = s.wData;
								4'h4:    next_s.r   = s.wData;
								4'h5:    next_s.n   = s.wData;
								4'h6:    next_s.endSec = s.wData;
								4'h7:    ;
								default: next_s.dtl = s.wData;
							endcase
							next_s.idx = s.idx + 4'h1;
							if (s.idx == `PARAM_COUNT)
							begin
								if (s.seekEn && s.seekBit)
								begin
									next_s.seekReq = 1'b1;
									next_s.phase   = PH_SEEK;
								end
								else
									next_s.phase = PH_SEARCH;
							end
						end
					default: ;
				endcase
		end

		// read channel: a data register read pops a result or a data byte
		if (s.rsp.rvalid && axiIn.rready)
			next_s.rsp.rvalid = 1'b0;
		if (axiIn.arvalid && s.rsp.arready)
		begin
			unique case (axiIn.araddr)
				`OFS_MAIN_STATUS: rdVal = mainStatus(s);
				`OFS_DRIVE_CTL:   rdVal = {4'h0, s.dmaEn, 3'h0};
				`OFS_RATE_SELECT: rdVal = {5'h00, s.scaled, s.rate};
				`OFS_MODE:        rdVal = {6'h00, s.noDma, s.seekEn};
				`OFS_DATA:
					if (s.phase == PH_RESULT)
					begin
						rdVal      = resultByte(s);
						next_s.irq = 1'b0;
						next_s.idx = s.idx + 4'h1;
						if (s.idx >= `RESULT_LAST)
							next_s.phase = PH_IDLE;
					end
					else if (exec && s.noDma && s.byteFull)
					begin
						rdVal           = s.dataByte;
						// set wins: a byte landing in this cycle survives the pop
						next_s.byteFull = next_s.byteFull && newByte;
						next_s.irq      = next_s.irq && (newByte || next_s.phase == PH_RESULT);
					end
				default: ;
			endcase
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata  = {24'h000000, rdVal};
			next_s.rsp.rresp  = mapped(axiIn.araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end

		next_s.rsp.awready = !next_s.awHave && !next_s.rsp.bvalid;
		next_s.rsp.wready  = !next_s.wHave && !next_s.rsp.bvalid;
		next_s.rsp.arready = !next_s.rsp.rvalid;
		next_s.precompNs   = precompFor(next_s.rate, next_s.scaled);
		next_s.coreClkSel  = coreFor(next_s.rate);
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s            <= '0;
			s.phase      <= PH_IDLE;
			s.rate       <= `RST_RATE;
			s.precompNs  <= `PRE_500K_NS;
			s.coreClkSel <= `CORE_8M;
		end
		else
			s <= next_s;
	end

	assign axiOut     = s.rsp;
	assign seekReq    = s.seekReq;
	assign seekTrack  = s.c;
	assign headSel    = s.hd;
	assign precompNs  = s.precompNs;
	assign coreClkSel = s.coreClkSel;
	assign rateSel    = s.rate;
	assign irq        = s.irq;
	assign irqOe      = s.dmaEn;
	assign dmaReq     = s.dmaReq;
	assign dmaReqOe   = s.dmaEn;
	assign dmaData    = s.dataByte;

endmodule : fdc_read_engine

// [logic/fdc_read_map.svh]
// register map, field positions, reset values and timing counts of the read-data engine
`ifndef FDC_READ_MAP_SVH
`define FDC_READ_MAP_SVH

`define OFS_MAIN_STATUS  8'h00
`define OFS_DATA         8'h04
`define OFS_DRIVE_CTL    8'h08
`define OFS_RATE_SELECT  8'h0C
`define OFS_MODE         8'h10

`define BIT_DMA_ENABLE   3
`define BIT_SCALED_PRE   2
`define BIT_SEEK_ENABLE  0
`define BIT_NO_DMA       1

`define MSR_REQUEST      7
`define MSR_TO_HOST      6
`define MSR_EXEC_NODMA   5
`define MSR_BUSY         4

`define SB1_END_TRACK    7
`define SB1_CRC          5
`define SB1_OVERRUN      4
`define SB1_NO_DATA      2
`define SB2_CONTROL_MARK 6
`define SB2_DATA_CRC     5
`define SB2_WRONG_TRACK  4
`define SB2_BAD_TRACK    1

`define OPC_READ_DATA    5'h06
`define BAD_TRACK_ID     8'hFF
`define PARAM_COUNT      4'h8
`define RESULT_LAST      4'h6
`define ST0_ABNORMAL     2'h1
`define ST0_INVALID      8'h80
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define RATE_500K        2'h0
`define RATE_300K        2'h1
`define RATE_250K        2'h2
`define RATE_1M          2'h3
`define RST_RATE         2'h0

`define CORE_4M          2'h0
`define CORE_4M8         2'h1
`define CORE_8M          2'h2

`define PRE_FIXED_NS     8'h7D
`define PRE_1M_NS        8'h53
`define PRE_250K_NS      8'hFA
`define PRE_300K_NS      8'hD0
`define PRE_500K_NS      8'h7D

`define MIN_SECTOR       14'h0080
`define CLK_NS           100
`define SETTLE_NS        100000
`define SETTLE_CYC       ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [logic/fdc_read_pkg.sv]
// types shared by the read-data engine: phases, bus carriers and the state record
package fdc_read_pkg;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_PARAM  = 3'b001,
		PH_SEEK   = 3'b010,
		PH_SETTLE = 3'b011,
		PH_SEARCH = 3'b100,
		PH_MARK   = 3'b101,
		PH_DATA   = 3'b110,
		PH_RESULT = 3'b111
	} phase_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axiReq_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axiRsp_s;

	typedef struct packed {
		logic       idValid;
		logic [7:0] idTrack;
		logic [7:0] idHead;
		logic [7:0] idSector;
		logic [7:0] idSize;
		logic       idCrcErr;
		logic       markValid;
		logic       markDeleted;
		logic       byteValid;
		logic [7:0] byteData;
		logic       fieldEnd;
		logic       fieldCrcErr;
		logic       indexPulse;
		logic       seekDone;
	} diskIn_s;

	typedef struct packed {
		phase_e      phase;
		logic [3:0]  idx;
		logic [7:0]  opc;
		logic        seekBit;
		logic        hd;
		logic [7:0]  c;
		logic [7:0]  h;
		logic [7:0]  r;
		logic [7:0]  n;
		logic [7:0]  endSec;
		logic [7:0]  dtl;
		logic [7:0]  st0;
		logic [7:0]  sb1;
		logic [7:0]  sb2;
		logic [13:0] byteCnt;
		logic        deleted;
		logic [1:0]  revs;
		logic [7:0]  dataByte;
		logic        byteFull;
		logic [11:0] settle;
		logic        termSeen;
		logic [2:0]  termSync;
		logic [2:0]  dackSync;
		logic        termLvl;
		logic        dackLvl;
		logic [1:0]  rate;
		logic        scaled;
		logic        dmaEn;
		logic        seekEn;
		logic        noDma;
		logic        awHave;
		logic        wHave;
		logic [7:0]  awAddr;
		logic [7:0]  wData;
		logic        wLane0;
		axiRsp_s     rsp;
		logic        irq;
		logic        dmaReq;
		logic        seekReq;
		logic [7:0]  precompNs;
		logic [1:0]  coreClkSel;
	} core_s;

endpackage : fdc_read_pkg

// [dv/fdc_read_engine_props.sv]
// port-level assertions and covers for the read-data engine
`timescale 1ns/100ps
module fdc_read_checker (
	// clock and reset
	input wire logic                  clock,
	input wire logic                  rst,
	// register bus
	input wire fdc_read_pkg::axiReq_s axiIn,
	input wire fdc_read_pkg::axiRsp_s axiOut,
	// data separator and drive
	input wire fdc_read_pkg::diskIn_s disk,
	input wire logic                  seekReq,
	input wire logic [7:0]            seekTrack,
	input wire logic                  headSel,
	input wire logic [7:0]            precompNs,
	input wire logic [1:0]            coreClkSel,
	input wire logic [1:0]            rateSel,
	// system DMA and interrupt
	input wire logic                  terminalCount,
	input wire logic                  dmaAckN,
	input wire logic                  irq,
	input wire logic                  irqOe,
	input wire logic                  dmaReq,
	input wire logic                  dmaReqOe,
	input wire logic [7:0]            dmaData
);
	import fdc_read_pkg::*;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_write_answer: assert property (axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready |-> ##[1:2] axiOut.bvalid)
		else $error("write response missing");
	a_read_answer: assert property (axiIn.arvalid && axiOut.arready |=> axiOut.rvalid)
		else $error("read response missing");
	a_bresp_held: assert property (axiOut.bvalid && !axiIn.bready |=> axiOut.bvalid && $stable(axiOut.bresp))
		else $error("write response dropped");
	a_rdata_held: assert property (axiOut.rvalid && !axiIn.rready |=> axiOut.rvalid && $stable(axiOut.rdata))
		else $error("read data dropped");
	a_byte_lane: assert property (axiOut.rvalid |-> axiOut.rdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	a_gate_pair: assert property (irqOe == dmaReqOe)
		else $error("interrupt and request gating differ");
	a_ack_release: assert property ($fell(dmaAckN) && dmaReq && dmaReqOe |-> ##[2:6] !dmaReq)
		else $error("request held after acknowledge");
	a_seek_track: assert property (seekReq && $past(seekReq) |-> $stable(seekTrack))
		else $error("seek track moved during seek");
	a_seek_end: assert property (seekReq && disk.seekDone |-> ##[1:2] !seekReq)
		else $error("seek request outlived seek done");
	a_clock_pick: assert property ($stable(rateSel) |-> coreClkSel == (rateSel == 2'h1 ? 2'h1 : rateSel == 2'h2 ? 2'h0 : 2'h2))
		else $error("core clock does not match rate");
	a_pre_fast: assert property ($stable(rateSel) && rateSel == 2'h3 |-> precompNs == 8'h53)
		else $error("precompensation wrong at top rate");
	a_pre_mid: assert property ($stable(rateSel) && rateSel == 2'h0 |-> precompNs == 8'h7D)
		else $error("precompensation wrong at 500k");
	a_pre_slow: assert property ($stable(rateSel) && rateSel inside {2'h1, 2'h2}
		|-> precompNs == 8'h7D || precompNs == (rateSel == 2'h1 ? 8'hD0 : 8'hFA))
		else $error("precompensation wrong at low rate");

	c_dma_byte: cover property ($fell(dmaReq));
	c_irq: cover property ($rose(irq));
	c_seek: cover property ($rose(seekReq));
endmodule : fdc_read_checker

bind fdc_read_engine fdc_read_checker chk (.*);

// [dv/dma_host_model.sv]
// system DMA controller model that takes bytes and ends the transfer by terminal count
`timescale 1ns/100ps
module dma_host_model #(
	parameter int TERM_AT = 4
) (
	// clock
	input  wire logic       clock,
	// engine side
	input  wire logic       dmaReq,
	input  wire logic       dmaReqOe,
	input  wire logic [7:0] dmaData,
	output      logic       dmaAckN,
	output      logic       terminalCount,
	// bookkeeping
	output      int         nBytes,
	output      logic [7:0] lastByte
);
	initial
	begin
		dmaAckN = 1'b1;
		terminalCount = 1'b0;
		nBytes = 0;
		lastByte = 8'h00;
		forever
		begin
			@(posedge clock);
			if (dmaReq && dmaReqOe)
			begin
				// odd bytes answered late to stretch the handshake
				repeat (nBytes % 2 * 3) @(posedge clock);
				dmaAckN <= 1'b0;
				lastByte <= dmaData;
				while (dmaReq) @(posedge clock);
				dmaAckN <= 1'b1;
				nBytes = nBytes + 1;
				if (nBytes == TERM_AT)
				begin
					terminalCount <= 1'b1;
					repeat (8) @(posedge clock);
					terminalCount <= 1'b0;
				end
			end
		end
	end
endmodule : dma_host_model

// [dv/tb_floppy_read_data_engine.sv]
// self-checking bench for the read-data engine
`timescale 1ns/100ps
`include "fdc_read_map.svh"
module tb_floppy_read_data_engine;
	import fdc_read_pkg::*;

	logic        clock;
	logic        rst;
	axiReq_s     axiIn;
	axiRsp_s     axiOut;
	diskIn_s     disk;
	logic        seekReq;
	logic [7:0]  seekTrack;
	logic        headSel;
	logic [7:0]  precompNs;
	logic [1:0]  coreClkSel;
	logic [1:0]  rateSel;
	logic        terminalCount;
	logic        dmaAckN;
	logic        irq;
	logic        irqOe;
	logic        dmaReq;
	logic        dmaReqOe;
	logic [7:0]  dmaData;
	int          nBytes;
	logic [7:0]  lastByte;
	int          n_mismatch;
	int          n_compared;
	logic [31:0] rdv;
	logic [1:0]  resp;
	logic [7:0]  res [7];

	fdc_read_engine uut (.*);
	dma_host_model dma (.*);

	always #50 clock = ~clock;

	task end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		axiIn.awvalid <= 1'b1;
		axiIn.awaddr <= a;
		axiIn.wvalid <= 1'b1;
		axiIn.wdata <= d;
		axiIn.wstrb <= 4'hF;
		axiIn.bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (axiOut.awready) axiIn.awvalid <= 1'b0;
			if (axiOut.wready) axiIn.wvalid <= 1'b0;
		end while (!axiOut.bvalid);
		resp = axiOut.bresp;
		axiIn.bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clock);
		axiIn.arvalid <= 1'b1;
		axiIn.araddr <= a;
		axiIn.rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (axiOut.arready) axiIn.arvalid <= 1'b0;
		end while (!axiOut.rvalid);
		rdv = axiOut.rdata;
		resp = axiOut.rresp;
		axiIn.rready <= 1'b0;
	endtask : rd

	// command and result bytes wait for the request flag
	task ready;
		rdv = 32'h0;
		while (!rdv[`MSR_REQUEST]) rd(`OFS_MAIN_STATUS);
	endtask : ready

	task cmd(input logic [7:0] p [9]);
		for (int i = 0; i < 9; i++)
		begin
			ready;
			wr(`OFS_DATA, {24'h0, p[i]});
		end
	endtask : cmd

	task results;
		while (!irq) @(posedge clock);
		for (int i = 0; i < 7; i++)
		begin
			ready;
			rd(`OFS_DATA);
			res[i] = rdv[7:0];
		end
	endtask : results

	task sector(input logic [7:0] t, input logic [7:0] r, input logic idBad, input logic dataBad);
		@(posedge clock);
		disk.idValid <= 1'b1;
		disk.idTrack <= t;
		disk.idHead <= 8'h00;
		disk.idSector <= r;
		disk.idSize <= 8'h00;
		disk.idCrcErr <= idBad;
		@(posedge clock);
		disk.idValid <= 1'b0;
		repeat (5) @(posedge clock);
		disk.markValid <= 1'b1;
		@(posedge clock);
		disk.markValid <= 1'b0;
		// spacing leaves room for terminal count to sync between bytes
		for (int i = 0; i < 128; i++)
		begin
			repeat (19) @(posedge clock);
			disk.byteValid <= 1'b1;
			disk.byteData <= i[7:0];
			@(posedge clock);
			disk.byteValid <= 1'b0;
		end
		disk.fieldEnd <= 1'b1;
		disk.fieldCrcErr <= dataBad;
		@(posedge clock);
		disk.fieldEnd <= 1'b0;
	endtask : sector

	task s_rates;
		chk({irqOe, dmaReqOe}, 32'h0);
		for (int s = 0; s < 2; s++)
			for (int r = 0; r < 4; r++)
			begin
				wr(`OFS_RATE_SELECT, {29'h0, s[0], r[1:0]});
				repeat (3) @(posedge clock);
				chk(rateSel, r);
				chk(coreClkSel, r == 1 ? 32'h1 : r == 2 ? 32'h0 : 32'h2);
				chk(precompNs, r == 3 ? 32'h53 : s == 0 || r == 0 ? 32'h7D : r == 1 ? 32'hD0 : 32'hFA);
			end
		wr(`OFS_RATE_SELECT, 32'h0);
		wr(`OFS_DRIVE_CTL, 32'h8);
		repeat (3) @(posedge clock);
		chk({irqOe, dmaReqOe}, 32'h3);
		rd(8'h40);
		chk(resp, `RESP_SLVERR);
	endtask : s_rates

	task s_dma_read;
		wr(`OFS_MODE, 32'h1);
		cmd('{8'h06, 8'h80, 8'h03, 8'h00, 8'h01, 8'h00, 8'h05, 8'h1B, 8'h04});
		while (!seekReq) @(posedge clock);
		chk(seekTrack, 8'h03);
		disk.seekDone <= 1'b1;
		@(posedge clock);
		disk.seekDone <= 1'b0;
		repeat (1100) @(posedge clock);
		sector(8'h03, 8'h01, 1'b0, 1'b0);
		results;
		chk(res[0][7:6], 2'h0);
		chk(res[5], 8'h02);
		chk(nBytes, 32'h4);
		chk(lastByte, 8'h03);
		wr(`OFS_MODE, 32'h0);
	endtask : s_dma_read

	task s_not_found;
		cmd('{8'h06, 8'h00, 8'h03, 8'h00, 8'h07, 8'h00, 8'h09, 8'h1B, 8'h80});
		for (int i = 0; i < 3; i++)
		begin
			repeat (10) @(posedge clock);
			disk.idValid <= 1'b1;
			disk.idTrack <= `BAD_TRACK_ID;
			disk.idSector <= 8'h07;
			@(posedge clock);
			disk.idValid <= 1'b0;
			disk.indexPulse <= 1'b1;
			@(posedge clock);
			disk.indexPulse <= 1'b0;
		end
		results;
		chk(res[0][7:6], `ST0_ABNORMAL);
		chk(res[1][`SB1_NO_DATA], 1'b1);
		chk(res[2][`SB2_BAD_TRACK], 1'b1);
		chk(res[5], 8'h07);
	endtask : s_not_found

	task s_abort;
		cmd('{8'h06, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h05, 8'h1B, 8'hFF});
		repeat (50) @(posedge clock);
		wr(`OFS_DATA, 32'h0);
		results;
		chk(res[0][7:6], `ST0_ABNORMAL);
		chk(res[1][`SB1_NO_DATA], 1'b0);
	endtask : s_abort

	task s_crc;
		for (int k = 0; k < 2; k++)
		begin
			cmd('{8'h06, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h05, 8'h1B, 8'h04});
			sector(8'h03, 8'h01, k == 0, k == 1);
			results;
			chk(res[0][7:6], `ST0_ABNORMAL);
			chk(res[1][`SB1_CRC], 1'b1);
			chk(res[2][`SB2_DATA_CRC], k[0]);
		end
	endtask : s_crc

	// non-DMA, multi-track: last sector of side zero moves on to side one
	task s_no_dma;
		wr(`OFS_MODE, 32'h2);
		cmd('{8'h86, 8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h05, 8'h1B, 8'h02});
		fork
			sector(8'h03, 8'h05, 1'b0, 1'b0);
			for (int i = 0; i < 2; i++)
			begin
				while (!irq) @(posedge clock);
				rd(`OFS_DATA);
				chk(rdv, i);
			end
		join
		repeat (2)
		begin
			@(posedge clock);
			disk.indexPulse <= 1'b1;
			@(posedge clock);
			disk.indexPulse <= 1'b0;
		end
		chk(headSel, 1'b1);
		results;
		chk(res[4], 8'h01);
		chk(res[5], 8'h01);
		wr(`OFS_MODE, 32'h0);
	endtask : s_no_dma

	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		axiIn = '0;
		disk = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		s_rates;
		s_dma_read;
		s_not_found;
		s_abort;
		s_crc;
		s_no_dma;
		end_sim;
	end

	// the whole sequence needs a little under a third of this
	initial
	begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		end_sim;
	end
endmodule : tb_floppy_read_data_engine
